/* design/gpio_bank_pkg.sv */
// Summary of operation
// - Writing pin_level drives each assigned output pin to its bit value.
// - Pin_level bits written for input pins are ignored and leave them unchanged.
// - Reading pin_level returns present level of every assigned pin, input or output.
// - Outputs changed by one write may move at slightly different moments.
// - Highz bit 1 floats an assigned output, 0 drives it; reset zero.
// - Open-drain bit 1 makes the output open drain, 0 push-pull; reset zero.
// - An open-drain output keeps a weak pull-up on while not pulling low.
// - Pull-up bit enables the input pin pull-up; all enabled after reset.
// - Pull-down bit enables the input pin pull-down; all disabled after reset.
// - Input interrupts need mask bit and a rise or fall enable; masks reset zero.
// - Mask bits of output pins have no effect; outputs never interrupt.
// - Rise enable plus mask raises an interrupt on each rising edge; reset ones.
// - Rise and fall both enabled raise interrupts on both edges.
// - Fall enable plus mask raises an interrupt on each falling edge; reset ones.
// - Function-select 1 hands the pin to this bank; 0 leaves it to the UART side.
// - Direction 0 makes an assigned pin an input, 1 an output; reset zero.
// - Writing 1 to set drives output high, to clear drives low; 0 does nothing.
`default_nettype none

package gpio_bank_pkg;
    localparam int PIN_CNT = 16;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;

    // Register offsets, one 16-bit register per address
    localparam logic [9:0] OFS_FUNC_SEL = 10'h3C0;
    localparam logic [9:0] OFS_DIR = 10'h3C1;
    localparam logic [9:0] OFS_SET = 10'h3C2;
    localparam logic [9:0] OFS_CLEAR = 10'h3C3;
    localparam logic [9:0] OFS_PIN_LEVEL = 10'h3C4;
    localparam logic [9:0] OFS_HIGHZ = 10'h3C5;
    localparam logic [9:0] OFS_OPENDRAIN = 10'h3C6;
    localparam logic [9:0] OFS_PULLUP = 10'h3C7;
    localparam logic [9:0] OFS_PULLDOWN = 10'h3C8;
    localparam logic [9:0] OFS_IRQ_MASK = 10'h3C9;
    localparam logic [9:0] OFS_RISE_EN = 10'h3CA;
    localparam logic [9:0] OFS_FALL_EN = 10'h3CB;

    // Reset values
    localparam logic [15:0] RST_FUNC_SEL = 16'h0000;
    localparam logic [15:0] RST_DIR = 16'h0000;
    localparam logic [15:0] RST_PIN_LEVEL = 16'h0000;
    localparam logic [15:0] RST_HIGHZ = 16'h0000;
    localparam logic [15:0] RST_OPENDRAIN = 16'h0000;
    localparam logic [15:0] RST_PULLUP = 16'hFFFF;
    localparam logic [15:0] RST_PULLDOWN = 16'h0000;
    localparam logic [15:0] RST_IRQ_MASK = 16'h0000;
    localparam logic [15:0] RST_RISE_EN = 16'hFFFF;
    localparam logic [15:0] RST_FALL_EN = 16'hFFFF;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;
endpackage : gpio_bank_pkg

`default_nettype wire

/* design/pin_evt_if.sv */
`default_nettype none

// Synchronised pin levels and their one-cycle edge pulses
interface pin_evt_if;
    import gpio_bank_pkg::*;
    logic [PIN_CNT-1:0] level;
    logic [PIN_CNT-1:0] rise;
    logic [PIN_CNT-1:0] fall;
    modport src (output level, rise, fall);
    modport dst (input level, rise, fall);
endinterface : pin_evt_if

`default_nettype wire

/* design/pin_sync_edge.sv */
`default_nettype none

module pin_sync_edge
    import gpio_bank_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [PIN_CNT-1:0] pad_in, // Raw pad levels
    pin_evt_if.src evt // Synchronised levels and edges
);
    logic [PIN_CNT-1:0] meta_ff;
    logic [PIN_CNT-1:0] sync_ff;
    logic [PIN_CNT-1:0] prev_ff;

    // Two-flop synchroniser; only the second stage is looked at.
    // Not reset, so the chain tracks the pins through reset and a pulled-up pin shows no false edge at release.
    always_ff @(posedge core_clk) begin
        meta_ff <= pad_in;
        sync_ff <= meta_ff;
    end

    // Previous sample, also running through reset
    always_ff @(posedge core_clk) begin
        prev_ff <= sync_ff;
    end

    // No edges are reported while reset is held; reset must last three edges to flush the chain
    assign evt.level = sync_ff;
    assign evt.rise = {PIN_CNT{nrst}} & sync_ff & ~prev_ff;
    assign evt.fall = {PIN_CNT{nrst}} & ~sync_ff & prev_ff;
endmodule : pin_sync_edge

`default_nettype wire

/* design/irq_event_latch.sv */
`default_nettype none

module irq_event_latch
    import gpio_bank_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [PIN_CNT-1:0] event_in, // Qualified edge events, one-cycle pulses
    input wire logic [PIN_CNT-1:0] collect, // Host clears these pending bits
    output logic [PIN_CNT-1:0] pending // Sticky pending events
);
    logic [PIN_CNT-1:0] pend_ff;

    // A new event in the clearing cycle survives: set beats clear
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pend_ff <= 16'h0000;
        end else begin
            pend_ff <= (pend_ff & ~collect) | event_in;
        end
    end

    assign pending = pend_ff;
endmodule : irq_event_latch

`default_nettype wire

/* design/gpio_bank_pad_irq_ctrl.sv */
`default_nettype none

module gpio_bank_pad_irq_ctrl
    import gpio_bank_pkg::*;
(
    input wire logic core_clk, // Core clock, 20 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic reg_rd, // Read strobe, one cycle
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    output logic [DATA_W-1:0] reg_rdata, // Read data, valid with reg_rvalid
    output logic reg_rvalid, // Read data valid pulse
    input wire logic [PIN_CNT-1:0] pad_in, // Pad input levels
    output logic [PIN_CNT-1:0] pad_out, // Pad output levels
    output logic [PIN_CNT-1:0] pad_oe_n, // Pad drive enable, low drives
    output logic [PIN_CNT-1:0] pad_pullup_en, // Weak pull-up enable
    output logic [PIN_CNT-1:0] pad_pulldown_en, // Weak pull-down enable
    input wire logic [PIN_CNT-1:0] alt_out, // UART/GPIO side output level
    input wire logic [PIN_CNT-1:0] alt_oe_n, // UART/GPIO side drive enable, low drives
    input wire logic [PIN_CNT-1:0] alt_pullup_en, // UART/GPIO side pull-up
    input wire logic [PIN_CNT-1:0] irq_collect, // Clears pending edge events
    output logic [PIN_CNT-1:0] irq_pending, // Latched edge events per pin
    output logic irq_out // Any pending event
);
    logic [PIN_CNT-1:0] func_sel_ff;
    logic [PIN_CNT-1:0] dir_ff;
    logic [PIN_CNT-1:0] out_level_ff;
    logic [PIN_CNT-1:0] nxt_out_level;
    logic [PIN_CNT-1:0] highz_ff;
    logic [PIN_CNT-1:0] opendrain_ff;
    logic [PIN_CNT-1:0] pullup_ff;
    logic [PIN_CNT-1:0] pulldown_ff;
    logic [PIN_CNT-1:0] irq_mask_ff;
    logic [PIN_CNT-1:0] rise_en_ff;
    logic [PIN_CNT-1:0] fall_en_ff;
    logic [PIN_CNT-1:0] pad_out_ff;
    logic [PIN_CNT-1:0] pad_oe_n_ff;
    logic [PIN_CNT-1:0] pad_pullup_ff;
    logic [PIN_CNT-1:0] pad_pulldown_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic rvalid_ff;
    logic [PIN_CNT-1:0] out_pins;
    logic [PIN_CNT-1:0] in_pins;
    logic [PIN_CNT-1:0] edge_event;
    logic wr_func_sel;
    logic wr_dir;
    logic wr_set;
    logic wr_clear;
    logic wr_level;

    pin_evt_if evt ();

    // Pins owned by this bank, split by direction
    assign out_pins = func_sel_ff & dir_ff;
    assign in_pins = func_sel_ff & ~dir_ff;

    // Address decode for writes
    assign wr_func_sel = reg_wr && (reg_addr == OFS_FUNC_SEL);
    assign wr_dir = reg_wr && (reg_addr == OFS_DIR);
    assign wr_set = reg_wr && (reg_addr == OFS_SET);
    assign wr_clear = reg_wr && (reg_addr == OFS_CLEAR);
    assign wr_level = reg_wr && (reg_addr == OFS_PIN_LEVEL);

    // Function select and direction
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            func_sel_ff <= RST_FUNC_SEL;
            dir_ff <= RST_DIR;
        end else begin
            if (wr_func_sel) begin
                func_sel_ff <= reg_wdata;
            end
            if (wr_dir) begin
                dir_ff <= reg_wdata;
            end
        end
    end

    // Output level: only assigned outputs take new bits, inputs keep theirs
    always_comb begin
        nxt_out_level = out_level_ff;
        if (wr_level) begin
            nxt_out_level = (out_level_ff & ~out_pins) | (reg_wdata & out_pins);
        end
        if (wr_set) begin
            nxt_out_level = out_level_ff | (reg_wdata & out_pins);
        end
        if (wr_clear) begin
            nxt_out_level = out_level_ff & ~(reg_wdata & out_pins);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            out_level_ff <= RST_PIN_LEVEL;
        end else begin
            out_level_ff <= nxt_out_level;
        end
    end

    // Pad configuration registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            highz_ff <= RST_HIGHZ;
            opendrain_ff <= RST_OPENDRAIN;
            pullup_ff <= RST_PULLUP;
            pulldown_ff <= RST_PULLDOWN;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFS_HIGHZ: highz_ff <= reg_wdata;
                OFS_OPENDRAIN: opendrain_ff <= reg_wdata;
                OFS_PULLUP: pullup_ff <= reg_wdata;
                OFS_PULLDOWN: pulldown_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Interrupt configuration registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_mask_ff <= RST_IRQ_MASK;
            rise_en_ff <= RST_RISE_EN;
            fall_en_ff <= RST_FALL_EN;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFS_IRQ_MASK: irq_mask_ff <= reg_wdata;
                OFS_RISE_EN: rise_en_ff <= reg_wdata;
                OFS_FALL_EN: fall_en_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Pad drive, registered so all pad outputs come from flops.
    // Every pin moves on the same edge here, but the pad ring may still skew them.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pad_out_ff <= 16'h0000;
            pad_oe_n_ff <= 16'hFFFF;
            pad_pullup_ff <= 16'h0000;
            pad_pulldown_ff <= 16'h0000;
        end else begin
            for (int i = 0; i < PIN_CNT; i++) begin
                if (!func_sel_ff[i]) begin
                    // Pin left to the UART/GPIO side
                    pad_out_ff[i] <= alt_out[i];
                    pad_oe_n_ff[i] <= alt_oe_n[i];
                    pad_pullup_ff[i] <= alt_pullup_en[i];
                    pad_pulldown_ff[i] <= 1'b0;
                end else if (dir_ff[i]) begin
                    // Assigned output: tri-state wins over drive style
                    pad_pulldown_ff[i] <= 1'b0;
                    if (highz_ff[i]) begin
                        pad_out_ff[i] <= 1'b0;
                        pad_oe_n_ff[i] <= 1'b1;
                        pad_pullup_ff[i] <= 1'b0;
                    end else if (opendrain_ff[i]) begin
                        pad_out_ff[i] <= 1'b0;
                        pad_oe_n_ff[i] <= out_level_ff[i];
                        pad_pullup_ff[i] <= out_level_ff[i];
                    end else begin
                        pad_out_ff[i] <= out_level_ff[i];
                        pad_oe_n_ff[i] <= 1'b0;
                        pad_pullup_ff[i] <= 1'b0;
                    end
                end else begin
                    // Assigned input: pulls as configured, never driven
                    pad_out_ff[i] <= 1'b0;
                    pad_oe_n_ff[i] <= 1'b1;
                    pad_pullup_ff[i] <= pullup_ff[i];
                    pad_pulldown_ff[i] <= pulldown_ff[i];
                end
            end
        end
    end

    assign pad_out = pad_out_ff;
    assign pad_oe_n = pad_oe_n_ff;
    assign pad_pullup_en = pad_pullup_ff;
    assign pad_pulldown_en = pad_pulldown_ff;

    // Input synchroniser and edge finder
    pin_sync_edge u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .pad_in(pad_in),
        .evt(evt.src)
    );

    // Qualify edges: input pins only, mask gates the chosen edge kinds.
    // A direction change can itself look like an edge; software should mask first.
    assign edge_event = in_pins & irq_mask_ff &
        ((evt.rise & rise_en_ff) | (evt.fall & fall_en_ff));

    irq_event_latch u_latch (
        .core_clk(core_clk),
        .nrst(nrst),
        .event_in(edge_event),
        .collect(irq_collect),
        .pending(irq_pending)
    );

    assign irq_out = |irq_pending;

    // Read mux; pin_level returns live pin state of assigned pins
    always_comb begin
        unique case (reg_addr)
            OFS_FUNC_SEL: nxt_rdata = func_sel_ff;
            OFS_DIR: nxt_rdata = dir_ff;
            OFS_PIN_LEVEL: nxt_rdata = evt.level & func_sel_ff;
            OFS_HIGHZ: nxt_rdata = highz_ff;
            OFS_OPENDRAIN: nxt_rdata = opendrain_ff;
            OFS_PULLUP: nxt_rdata = pullup_ff;
            OFS_PULLDOWN: nxt_rdata = pulldown_ff;
            OFS_IRQ_MASK: nxt_rdata = irq_mask_ff;
            OFS_RISE_EN: nxt_rdata = rise_en_ff;
            OFS_FALL_EN: nxt_rdata = fall_en_ff;
            default: nxt_rdata = RD_UNMAPPED; // Set/clear are write-only
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
endmodule : gpio_bank_pad_irq_ctrl

`default_nettype wire

/* tb/pin_periph_model.sv */
`default_nettype none

module pin_periph_model
    import gpio_bank_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic [PIN_CNT-1:0] pad_out, // Device level
    input wire logic [PIN_CNT-1:0] pad_oe_n, // Device drive, low drives
    input wire logic [PIN_CNT-1:0] pad_pullup_en, // Weak up
    input wire logic [PIN_CNT-1:0] pad_pulldown_en, // Weak down
    input wire logic [PIN_CNT-1:0] ext_en, // Peripheral drives
    input wire logic [PIN_CNT-1:0] ext_lvl, // Peripheral level
    output logic [PIN_CNT-1:0] pad_in // Resolved wire
);
    logic [PIN_CNT-1:0] last_ff = '1;

    // Last wire level, so a floating pin shows a changing value, not a lucky constant
    always_ff @(posedge core_clk) begin
        last_ff <= pad_in;
    end

    // Device drive wins, then the peripheral, then a single weak pull
    always_comb begin
        for (int i = 0; i < PIN_CNT; i++) begin
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_lvl[i] :
                (pad_pullup_en[i] ^ pad_pulldown_en[i]) ? pad_pullup_en[i] : ~last_ff[i];
        end
    end
endmodule : pin_periph_model

`default_nettype wire

/* tb/gpio_bank_properties.sv */
`default_nettype none

module gpio_bank_checker
    import gpio_bank_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic [ADDR_W-1:0] reg_addr, // Address
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [DATA_W-1:0] reg_wdata, // Wdata
    input wire logic [DATA_W-1:0] reg_rdata, // Rdata
    input wire logic reg_rvalid, // Rvalid
    input wire logic [PIN_CNT-1:0] pad_in, // Pads
    input wire logic [PIN_CNT-1:0] pad_out, // Out
    input wire logic [PIN_CNT-1:0] pad_oe_n, // Drive
    input wire logic [PIN_CNT-1:0] pad_pullup_en, // Up
    input wire logic [PIN_CNT-1:0] pad_pulldown_en, // Down
    input wire logic [PIN_CNT-1:0] alt_out, // Alt
    input wire logic [PIN_CNT-1:0] alt_oe_n, // Alt drive
    input wire logic [PIN_CNT-1:0] alt_pullup_en, // Alt up
    input wire logic [PIN_CNT-1:0] irq_collect, // Collect
    input wire logic [PIN_CNT-1:0] irq_pending, // Pending
    input wire logic irq_out // Irq
);
    logic [15:0] cfg_ff [0:11];
    logic [15:0] lvl_ff, rd_exp, out_m, pp_m, hz_m, od_m, in_m, arm_r, arm_f;
    logic cfg_hit;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Shadow of the configuration words, indexed by the low address nibble
    assign cfg_hit = reg_addr >= OFS_FUNC_SEL && reg_addr <= OFS_FALL_EN && reg_addr != OFS_SET && reg_addr != OFS_CLEAR;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_ff <= '{RST_FUNC_SEL, RST_DIR, 16'h0000, 16'h0000, RST_PIN_LEVEL, RST_HIGHZ, RST_OPENDRAIN,
                RST_PULLUP, RST_PULLDOWN, RST_IRQ_MASK, RST_RISE_EN, RST_FALL_EN};
        end else if (reg_wr && cfg_hit) begin
            cfg_ff[reg_addr[3:0]] <= reg_wdata;
        end
    end

    // Output level: only assigned outputs take level, set and clear writes
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            lvl_ff <= RST_PIN_LEVEL;
        end else if (reg_wr && reg_addr == OFS_PIN_LEVEL) begin
            lvl_ff <= (lvl_ff & ~out_m) | (reg_wdata & out_m);
        end else if (reg_wr && reg_addr == OFS_SET) begin
            lvl_ff <= lvl_ff | (reg_wdata & out_m);
        end else if (reg_wr && reg_addr == OFS_CLEAR) begin
            lvl_ff <= lvl_ff & ~(reg_wdata & out_m);
        end
    end

    // Pin classes from the shadow
    assign rd_exp = cfg_hit ? cfg_ff[reg_addr[3:0]] : RD_UNMAPPED;
    assign out_m = cfg_ff[0] & cfg_ff[1];
    assign pp_m = out_m & ~cfg_ff[5] & ~cfg_ff[6];
    assign hz_m = out_m & cfg_ff[5];
    assign od_m = out_m & ~cfg_ff[5] & cfg_ff[6];
    assign in_m = cfg_ff[0] & ~cfg_ff[1];
    assign arm_r = in_m & cfg_ff[9] & cfg_ff[10];
    assign arm_f = in_m & cfg_ff[9] & cfg_ff[11];

    // An edge on an armed pin that stays armed while it crosses the synchroniser
    sequence s_armed_edge(ev, arm);
        ev && arm ##1 arm [*3];
    endsequence

    AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
        else $error("Read strobe got no valid pulse");
    AST_CFG_READBACK: assert property (reg_rd && !reg_wr && reg_addr != OFS_PIN_LEVEL |=> reg_rdata == $past(rd_exp))
        else $error("Register read value wrong");
    AST_PUSHPULL: assert property ((((pad_out ^ $past(lvl_ff)) | pad_oe_n | pad_pulldown_en) & pp_m & $past(pp_m)) == '0)
        else $error("Push-pull output wrong");
    AST_HIGHZ: assert property ((~pad_oe_n & hz_m & $past(hz_m)) == '0)
        else $error("Tri-stated output driven");
    AST_OPENDRAIN: assert property ((((pad_oe_n ^ $past(lvl_ff)) | (pad_oe_n & ~pad_pullup_en)
        | (~pad_oe_n & pad_out)) & od_m & $past(od_m)) == '0)
        else $error("Open-drain output wrong");
    AST_INPUT_PULLS: assert property ((((pad_pullup_en ^ $past(cfg_ff[7]))
        | (pad_pulldown_en ^ $past(cfg_ff[8])) | ~pad_oe_n) & in_m & $past(in_m)) == '0)
        else $error("Input pin pulls wrong");
    AST_UNASSIGNED_ALT: assert property ($past(nrst) |-> (((pad_out ^ $past(alt_out))
        | (pad_oe_n ^ $past(alt_oe_n)) | (pad_pullup_en ^ $past(alt_pullup_en)) | pad_pulldown_en)
        & ~cfg_ff[0] & ~$past(cfg_ff[0])) == '0)
        else $error("Unassigned pin does not follow alternate side");
    AST_OUTPUT_NO_IRQ: assert property ((irq_pending & ~$past(irq_pending) & out_m & $past(out_m)
        & $past(out_m, 2) & $past(out_m, 3)) == '0)
        else $error("Output pin raised an event");
    AST_IRQ_ANY: assert property (irq_out == (|irq_pending))
        else $error("Interrupt line disagrees with pending bits");
    // A new pending bit needs an input pin with its mask and at least one edge kind enabled
    AST_IRQ_QUALIFIED: assert property ((irq_pending & ~$past(irq_pending)
        & ~$past(in_m & cfg_ff[9] & (cfg_ff[10] | cfg_ff[11]))) == '0)
        else $error("Event latched on a pin that is not armed");
    for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin
        AST_RISE_EVENT: assert property (s_armed_edge($rose(pad_in[i]), arm_r[i]) |-> ##[0:1] irq_pending[i])
            else $error("Rising edge not latched");
        AST_FALL_EVENT: assert property (s_armed_edge($fell(pad_in[i]), arm_f[i]) |-> ##[0:1] irq_pending[i])
            else $error("Falling edge not latched");
    end
endmodule : gpio_bank_checker

bind gpio_bank_pad_irq_ctrl gpio_bank_checker u_chk (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
    .pad_pulldown_en(pad_pulldown_en), .alt_out(alt_out), .alt_oe_n(alt_oe_n), .alt_pullup_en(alt_pullup_en),
    .irq_collect(irq_collect), .irq_pending(irq_pending), .irq_out(irq_out));

`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_bank_pkg::*;

    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid, irq_out;
    logic [PIN_CNT-1:0] pad_in, pad_out, pad_oe_n, pad_pullup_en, pad_pulldown_en, irq_pending;
    logic [PIN_CNT-1:0] alt_out = '0, alt_oe_n = '1, alt_pullup_en = '0, irq_collect = '0, ext_en = '0, ext_lvl = '0;
    logic [15:0] d, v, m, r, f, o, e;
    int mismatches = 0;
    int total_checks = 0;

    gpio_bank_pad_irq_ctrl dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en), .pad_pulldown_en(pad_pulldown_en),
        .alt_out(alt_out), .alt_oe_n(alt_oe_n), .alt_pullup_en(alt_pullup_en), .irq_collect(irq_collect),
        .irq_pending(irq_pending), .irq_out(irq_out));
    pin_periph_model periph (.core_clk(core_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_en(pad_pullup_en), .pad_pulldown_en(pad_pulldown_en), .ext_en(ext_en), .ext_lvl(ext_lvl),
        .pad_in(pad_in));

    // 20 MHz core clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // Reset value of each address; set, clear and unmapped places read zero
    function automatic logic [15:0] rst_val(input logic [9:0] a);
        return (a == OFS_PULLUP || a == OFS_RISE_EN || a == OFS_FALL_EN) ? 16'hFFFF : 16'h0000;
    endfunction : rst_val

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic wr(input logic [9:0] a, input logic [15:0] dat);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = dat;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    // The valid pulse stands one cycle, so it is looked at in that cycle
    task automatic rd_chk(input string name, input logic [9:0] a, input logic [15:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
        chk(name, reg_rdata, exp);
    endtask : rd_chk

    // Collect every pending event once the pins have settled
    task automatic collect();
        cyc(5);
        irq_collect = '1;
        cyc(2);
        irq_collect = '0;
        chk("collect", irq_pending, 16'h0000);
    endtask : collect

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Whole run is under 1500 cycles; a hang ends at the 20000-cycle budget, well above the run
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h32436A2C));
        cyc(8);
        nrst = 1'b1;
        for (int a = 'h3BF; a <= 'h3CC; a++) begin
            rd_chk("reset", a[9:0], rst_val(a[9:0]));
        end
        $display("Test reset values done");
        for (int a = 'h3C5; a <= 'h3CB; a++) begin
            v = 16'($urandom);
            wr(a[9:0], v);
            rd_chk("cfg", a[9:0], v);
        end
        $display("Test readback done");
        // Level bits of input pins are dropped, so only d survives the switch to outputs
        d = 16'($urandom);
        wr(OFS_FUNC_SEL, 16'hFFFF);
        wr(OFS_DIR, d);
        wr(OFS_HIGHZ, 16'h0000);
        wr(OFS_OPENDRAIN, 16'h0000);
        wr(OFS_PIN_LEVEL, 16'hFFFF);
        wr(OFS_DIR, 16'hFFFF);
        cyc(3);
        chk("pad_out", pad_out, d);
        chk("pad_oe_n", pad_oe_n, 16'h0000);
        v = 16'($urandom);
        m = 16'($urandom);
        wr(OFS_SET, v);
        wr(OFS_CLEAR, m);
        cyc(5);
        chk("set_clear", pad_out, (d | v) & ~m);
        rd_chk("level_out", OFS_PIN_LEVEL, (d | v) & ~m);
        $display("Test output drive done");
        v = 16'($urandom);
        m = 16'($urandom);
        o = 16'($urandom);
        e = m | (o & ~m & v);
        wr(OFS_PIN_LEVEL, v);
        wr(OFS_HIGHZ, m);
        wr(OFS_OPENDRAIN, o);
        cyc(3);
        chk("oe_mode", pad_oe_n, e);
        chk("od_pullup", pad_pullup_en & o & ~m & v, o & ~m & v);
        chk("driven", pad_out & ~e, v & ~e);
        $display("Test drive modes done");
        v = 16'($urandom);
        m = 16'($urandom);
        wr(OFS_DIR, 16'h0000);
        wr(OFS_PULLUP, v);
        wr(OFS_PULLDOWN, m);
        cyc(3);
        chk("pullup", pad_pullup_en, v);
        chk("pulldown", pad_pulldown_en, m);
        chk("in_oe_n", pad_oe_n, 16'hFFFF);
        $display("Test input pulls done");
        ext_en = '1;
        ext_lvl = 16'($urandom);
        d = 16'($urandom);
        alt_out = 16'($urandom);
        alt_oe_n = 16'($urandom);
        alt_pullup_en = 16'($urandom);
        wr(OFS_FUNC_SEL, d);
        cyc(4);
        chk("alt_out", pad_out & ~d, alt_out & ~d);
        rd_chk("level_in", OFS_PIN_LEVEL, ext_lvl & d);
        $display("Test function select done");
        // Rise only, fall only, then both; output pins toggle too but stay silent
        wr(OFS_FUNC_SEL, 16'hFFFF);
        for (int k = 1; k < 4; k++) begin
            o = 16'($urandom);
            m = 16'($urandom);
            r = k[0] ? 16'($urandom) : 16'h0000;
            f = k[1] ? 16'($urandom) : 16'h0000;
            wr(OFS_DIR, o);
            wr(OFS_IRQ_MASK, m);
            wr(OFS_RISE_EN, r);
            wr(OFS_FALL_EN, f);
            ext_lvl = '0;
            wr(OFS_PIN_LEVEL, 16'h0000);
            collect();
            ext_lvl = '1;
            wr(OFS_PIN_LEVEL, 16'hFFFF);
            cyc(5);
            chk("irq_rise", irq_pending, m & r & ~o);
            chk("irq_out", {15'h0000, irq_out}, {15'h0000, |(m & r & ~o)});
            collect();
            ext_lvl = '0;
            wr(OFS_PIN_LEVEL, 16'h0000);
            cyc(5);
            chk("irq_fall", irq_pending, m & f & ~o);
        end
        $display("Test interrupts done");
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
